// ==== gd_monitor.sv ====
// port checker for the gate drive control block
`default_nettype none

module gd_monitor #(
  parameter int NPH = 3
) (
  input wire logic           aclk,
  input wire logic           aresetn,
  input wire logic [NPH-1:0] high_side_input,
  input wire logic [NPH-1:0] low_side_input,
  input wire logic [NPH-1:0] high_gate_out,
  input wire logic [NPH-1:0] low_gate_out,
  input wire logic [NPH-1:0] phase_node_float,
  input wire logic           supply_lockout,
  input wire logic           thermal_shutdown,
  input wire logic           fault_out_n
);
  // ********
  // checks
  // ********
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // both requests high on phase 0
  sequence s_both;
    high_side_input[0] && low_side_input[0];
  endsequence
  // low gate kept off through the dead window
  sequence s_low_off;
    (!low_gate_out[0]) [*3];
  endsequence

  chk_no_overlap: assert property ((high_gate_out & low_gate_out) == '0)
    else $error("both gates of a phase on");
  chk_float_match: assert property (phase_node_float == ~(high_gate_out | low_gate_out))
    else $error("float flag disagrees with gates");
  chk_dead_gap: assert property ($fell(high_gate_out[0]) |-> s_low_off)
    else $error("low gate on inside dead time");
  chk_high_cause: assert property ($rose(high_gate_out[0]) |->
      $past(high_side_input[0]) && !$past(low_side_input[0]))
    else $error("high gate on without high-only request");
  chk_low_cause: assert property ($rose(low_gate_out[0]) |->
      $past(low_side_input[0]) && !$past(high_side_input[0]))
    else $error("low gate on without low-only request");
  chk_both_off: assert property (s_both ##1 s_both |-> !high_gate_out[0] && !low_gate_out[0])
    else $error("gate on with both requests high");
  chk_fault_pin: assert property (supply_lockout |-> ##[1:2] !fault_out_n)
    else $error("fault pin not low on lockout");
  chk_shutdown_off: assert property (thermal_shutdown [*4] |->
      high_gate_out == '0 && low_gate_out == '0)
    else $error("gates on during thermal shutdown");
endmodule : gd_monitor

bind gd_top gd_monitor #(.NPH(NPH)) u_gd_monitor (
  .aclk(aclk), .aresetn(aresetn), .high_side_input(high_side_input),
  .low_side_input(low_side_input), .high_gate_out(high_gate_out),
  .low_gate_out(low_gate_out), .phase_node_float(phase_node_float),
  .supply_lockout(supply_lockout), .thermal_shutdown(thermal_shutdown),
  .fault_out_n(fault_out_n));

`default_nettype wire

// ==== gd_ocp.sv ====
// overcurrent filter and retry timer
`default_nettype none

module gd_ocp
  import gd_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              oc_in,
  input  wire logic [CNT_W-1:0]  filt_cyc,
  input  wire logic [CNT_W-1:0]  retry_cyc,
  output logic                   oc_fault,
  output logic                   oc_event
);

  gd_oc_type         state_r, state_nxt;
  logic [CNT_W-1:0]  cnt_r, cnt_nxt;
  logic              ev_r, ev_nxt;

  // ****************************************************************
  // filter then retry; any gap in the condition restarts the filter
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    ev_nxt    = 1'b0;
    unique case (state_r)
      OC_WATCH: begin
        if (!oc_in) begin
          cnt_nxt = '0;  // short excursion ignored
        end else if (cnt_r + 1'b1 >= filt_cyc) begin
          state_nxt = OC_RETRY;
          cnt_nxt   = '0;
          ev_nxt    = 1'b1;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      OC_RETRY: begin
        // gates held off for the retry wait, then watch again
        if (cnt_r + 1'b1 >= retry_cyc) begin
          state_nxt = OC_WATCH;
          cnt_nxt   = '0;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= OC_WATCH;
      cnt_r   <= '0;
      ev_r    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      ev_r    <= ev_nxt;
    end
  end

  assign oc_fault = (state_r == OC_RETRY);
  assign oc_event = ev_r;

endmodule : gd_ocp

`default_nettype wire

// ==== gd_phase.sv ====
// one half-bridge sequencer with dead time between the two gates
`default_nettype none

module gd_phase
  import gd_pkg::*;
#(
  parameter int DEAD = DEAD_CYC
) (
  input  wire logic   aclk,
  input  wire logic   aresetn,
  gd_phase_if.phase   ph
);

  gd_phase_type      state_r, state_nxt;
  logic [7:0]        cnt_r, cnt_nxt;
  logic              gh_r, gh_nxt, gl_r, gl_nxt, fl_r, fl_nxt;

  // ****************************************************************
  // sequencer: a conducting gate always passes through dead time
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    unique case (state_r)
      PH_OFF: begin
        if (!ph.kill && ph.want_high && !ph.want_low) begin
          state_nxt = PH_HIGH;
        end else if (!ph.kill && ph.want_low && !ph.want_high) begin
          state_nxt = PH_LOW;
        end
      end
      PH_DEAD: begin
        // both gates low until the count runs out
        if (cnt_r == 8'h00) begin
          state_nxt = PH_OFF;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      PH_HIGH: begin
        if (ph.kill || !ph.want_high || ph.want_low) begin
          state_nxt = PH_DEAD;
          cnt_nxt   = 8'(DEAD - 1);
        end
      end
      PH_LOW: begin
        if (ph.kill || !ph.want_low || ph.want_high) begin
          state_nxt = PH_DEAD;
          cnt_nxt   = 8'(DEAD - 1);
        end
      end
    endcase
    gh_nxt = (state_nxt == PH_HIGH);
    gl_nxt = (state_nxt == PH_LOW);
    fl_nxt = !gh_nxt && !gl_nxt;  // neither gate on leaves the node floating
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= PH_OFF;
      cnt_r   <= 8'h00;
      gh_r    <= 1'b0;
      gl_r    <= 1'b0;
      fl_r    <= 1'b1;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      gh_r    <= gh_nxt;
      gl_r    <= gl_nxt;
      fl_r    <= fl_nxt;
    end
  end

  assign ph.gate_high = gh_r;
  assign ph.gate_low  = gl_r;
  assign ph.floating  = fl_r;

endmodule : gd_phase

`default_nettype wire

// ==== gd_phase_if.sv ====
// interface between the top control and one half-bridge sequencer
`default_nettype none

interface gd_phase_if;
  logic want_high;   // decoded request for high gate
  logic want_low;    // decoded request for low gate
  logic kill;        // force both gates off
  logic gate_high;   // sequenced high gate
  logic gate_low;    // sequenced low gate
  logic floating;    // phase node left floating

  modport ctrl  (output want_high, output want_low, output kill,
                 input gate_high, input gate_low, input floating);
  modport phase (input want_high, input want_low, input kill,
                 output gate_high, output gate_low, output floating);
endinterface : gd_phase_if

`default_nettype wire

// ==== gd_pkg.sv ====
// constants, register map and types of the gate drive block
//
// Behaviour
// - four input modes, chosen by field or strap; only six-input is decoded, other modes keep gates low
// - six-input mode at field 00b or strap high
// - six-input decode: one side only drives gate
// - overcurrent filter 1/2/4/8 us, fixed 4 us
// - retry wait 8 ms or 50 us, fixed 8 ms
// - detect faults, drive fault pin, record details
// - state machine inserts dead time, guards shorts
// - settings by registers, or straps on hardware
`default_nettype none

package gd_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 100;
  localparam int FILT_T0_US     = 1;
  localparam int FILT_T1_US     = 2;
  localparam int FILT_T2_US     = 4;
  localparam int FILT_T3_US     = 8;
  localparam int RETRY_LONG_MS  = 8;
  localparam int RETRY_SHORT_US = 50;
  localparam int DEAD_NS        = 200;
  // least times round up to whole cycles
  localparam int FILT_CYC0  = (FILT_T0_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_CYC1  = (FILT_T1_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_CYC2  = (FILT_T2_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_CYC3  = (FILT_T3_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETRY_LONG_CYC  = (RETRY_LONG_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETRY_SHORT_CYC = (RETRY_SHORT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEAD_CYC        = (DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W           = 17;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam int         ADDR_W       = 8;
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] STATUS_OFS   = 8'h04;
  localparam logic [7:0] MASK_OFS     = 8'h08;
  localparam logic [7:0] LIVE_OFS     = 8'h0C;
  // control fields
  localparam int         CTRL_MODE_LSB  = 0;
  localparam int         CTRL_FILT_LSB  = 2;
  localparam int         CTRL_RETRY_BIT = 4;
  localparam int         CTRL_W         = 5;
  localparam logic [4:0] CTRL_RST       = 5'h00;
  localparam logic [1:0] MODE_SIX       = 2'h0;
  // fault bits, shared by status, mask and live registers
  localparam int         NFLT         = 6;
  localparam int         FLT_LOCKOUT  = 0;
  localparam int         FLT_GATE_SUPPLY_UNDERVOLTAGE     = 1;
  localparam int         FLT_OC       = 2;
  localparam int         FLT_GSHORT   = 3;
  localparam int         FLT_TSD      = 4;
  localparam int         FLT_TWARN    = 5;
  localparam logic [5:0] FLT_RST      = 6'h00;
  localparam logic [5:0] MASK_RST     = 6'h00;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  // ****************************************************************
  // state types
  // ****************************************************************
  typedef enum logic [1:0] {
    PH_OFF  = 2'b00,
    PH_DEAD = 2'b01,
    PH_HIGH = 2'b10,
    PH_LOW  = 2'b11
  } gd_phase_type;

  typedef enum logic [0:0] {
    OC_WATCH = 1'b0,
    OC_RETRY = 1'b1
  } gd_oc_type;

endpackage : gd_pkg

`default_nettype wire

// ==== gd_pwm_src.sv ====
// pwm source standing in for the external motor controller
`default_nettype none

module gd_pwm_src #(
  parameter int NPH = 3
) (
  input  wire logic           aclk,
  input  wire logic [NPH-1:0] want_high,
  input  wire logic [NPH-1:0] want_low,
  input  wire logic           quiet,
  output var logic  [NPH-1:0] high_side_input = '0,
  output var logic  [NPH-1:0] low_side_input = '0
);
  timeunit 1ns;
  timeprecision 1ns;
  // quiet parks all inputs low and is held across any mode change
  always @(posedge aclk) begin
    high_side_input <= quiet ? '0 : want_high;
    low_side_input  <= quiet ? '0 : want_low;
  end
endmodule : gd_pwm_src

`default_nettype wire

// ==== gd_top.sv ====
// gate drive control: input decode, dead time, fault timing and register slave
//
// Chosen here: the address map and register access over AXI4-Lite.
`default_nettype none

module gd_top
  import gd_pkg::*;
#(
  parameter int NPH        = 3,
  parameter int RETRY_LONG = RETRY_LONG_CYC,
  parameter int RETRY_SHRT = RETRY_SHORT_CYC
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // straps, caught once after reset release
  input  wire logic              hw_variant_strap,
  input  wire logic              mode_strap_agnd,
  // pwm inputs from the controller
  input  wire logic [NPH-1:0]    high_side_input,
  input  wire logic [NPH-1:0]    low_side_input,
  // fault monitors
  input  wire logic              supply_lockout,
  input  wire logic              gate_supply_undervoltage,
  input  wire logic [NPH-1:0]    overcurrent_in,
  input  wire logic [NPH-1:0]    gate_short_detect,
  input  wire logic              thermal_shutdown,
  input  wire logic              thermal_warning,
  // outputs
  output logic [NPH-1:0]         high_gate_out,
  output logic [NPH-1:0]         low_gate_out,
  output logic [NPH-1:0]         phase_node_float,
  output logic                   fault_out_n,
  output logic                   irq
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic                 strap_done_r, strap_done_nxt;
  logic                 hw_r, hw_nxt;
  logic                 strap6_r, strap6_nxt;
  logic [CTRL_W-1:0]    ctrl_r, ctrl_nxt;
  logic [NFLT-1:0]      status_r, status_nxt;
  logic [NFLT-1:0]      mask_r, mask_nxt;
  logic                 aw_full_r, aw_full_nxt;
  logic [ADDR_W-1:0]    awaddr_r, awaddr_nxt;
  logic                 w_full_r, w_full_nxt;
  logic [31:0]          wdata_r, wdata_nxt;
  logic                 wstrb0_r, wstrb0_nxt;
  logic                 awready_r, awready_nxt;
  logic                 wready_r, wready_nxt;
  logic                 bvalid_r, bvalid_nxt;
  logic [1:0]           bresp_r, bresp_nxt;
  logic                 arready_r, arready_nxt;
  logic                 rvalid_r, rvalid_nxt;
  logic [1:0]           rresp_r, rresp_nxt;
  logic [31:0]          rdata_r, rdata_nxt;
  logic                 fault_n_r, fault_n_nxt;
  logic                 irq_r, irq_nxt;

  // combinational helpers
  logic                 six_mode;
  logic [1:0]           filt_sel;
  logic                 retry_sel;
  logic [CNT_W-1:0]     filt_cyc, retry_cyc;
  logic                 oc_fault, oc_event;
  logic [NFLT-1:0]      live;
  logic                 shutdown;
  logic                 do_write;
  logic [NFLT-1:0]      w1c;

  gd_phase_if ph_if [NPH] ();

  // ****************************************************************
  // mode and timing selection
  // ****************************************************************
  // serial variant uses register fields, hardware variant the straps
  assign six_mode  = hw_r ? strap6_r
                          : (ctrl_r[CTRL_MODE_LSB +: 2] == MODE_SIX);
  assign filt_sel  = ctrl_r[CTRL_FILT_LSB +: 2];
  assign retry_sel = ctrl_r[CTRL_RETRY_BIT];

  // filter time per select code, fixed 4 us on hardware variant
  always_comb begin
    unique case (hw_r ? 2'h2 : filt_sel)
      2'h0: filt_cyc = CNT_W'(FILT_CYC0);
      2'h1: filt_cyc = CNT_W'(FILT_CYC1);
      2'h2: filt_cyc = CNT_W'(FILT_CYC2);
      2'h3: filt_cyc = CNT_W'(FILT_CYC3);
    endcase
  end

  // long wait unless the serial variant selects the short one
  assign retry_cyc = (!hw_r && retry_sel) ? CNT_W'(RETRY_SHRT)
                                          : CNT_W'(RETRY_LONG);

  // ****************************************************************
  // fault detection
  // ****************************************************************
  gd_ocp u_ocp (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .oc_in     (|overcurrent_in),
    .filt_cyc  (filt_cyc),
    .retry_cyc (retry_cyc),
    .oc_fault  (oc_fault),
    .oc_event  (oc_event)
  );

  // live view of each fault condition
  always_comb begin
    live              = '0;
    live[FLT_LOCKOUT] = supply_lockout;
    live[FLT_GATE_SUPPLY_UNDERVOLTAGE]    = gate_supply_undervoltage;
    live[FLT_OC]      = oc_fault | oc_event;
    live[FLT_GSHORT]  = |gate_short_detect;
    live[FLT_TSD]     = thermal_shutdown;
    live[FLT_TWARN]   = thermal_warning;
  end

  // warning only reports; every other fault turns the gates off
  assign shutdown = |live[FLT_TSD:FLT_LOCKOUT];

  // ****************************************************************
  // half-bridge sequencers
  // ****************************************************************
  // other modes are not decoded: gates stay low
  generate
    for (genvar p = 0; p < NPH; p++) begin : g_ph
      assign ph_if[p].want_high = six_mode && high_side_input[p];
      assign ph_if[p].want_low  = six_mode && low_side_input[p];
      assign ph_if[p].kill      = shutdown || !strap_done_r;
      gd_phase u_phase (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ph      (ph_if[p].phase)
      );
      assign high_gate_out[p]    = ph_if[p].gate_high;
      assign low_gate_out[p]     = ph_if[p].gate_low;
      assign phase_node_float[p] = ph_if[p].floating;
    end
  endgenerate

  // ****************************************************************
  // bus decode helpers
  // ****************************************************************
  assign do_write = aw_full_r && w_full_r && !bvalid_r;
  assign w1c      = (do_write && wstrb0_r && awaddr_r == STATUS_OFS)
                    ? wdata_r[NFLT-1:0] : '0;

  // ****************************************************************
  // next state of straps, registers and bus
  // ****************************************************************
  always_comb begin
    strap_done_nxt = 1'b1;
    hw_nxt         = hw_r;
    strap6_nxt     = strap6_r;
    // straps are sampled in the first cycle after reset release
    if (!strap_done_r) begin
      hw_nxt     = hw_variant_strap;
      strap6_nxt = mode_strap_agnd;
    end
    ctrl_nxt    = ctrl_r;
    mask_nxt    = mask_r;
    // a fault present in the clearing cycle stays recorded
    status_nxt  = (status_r & ~w1c) | live;
    aw_full_nxt = aw_full_r;
    awaddr_nxt  = awaddr_r;
    w_full_nxt  = w_full_r;
    wdata_nxt   = wdata_r;
    wstrb0_nxt  = wstrb0_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    // address and data are taken independently, in either order
    if (s_axi_awvalid && awready_r) begin
      aw_full_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      w_full_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstrb0_nxt = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    // write once both halves are held; only byte lane 0 carries fields
    if (do_write) begin
      aw_full_nxt = 1'b0;
      w_full_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = RESP_OKAY;
      unique case (awaddr_r)
        CTRL_OFS:   if (wstrb0_r) ctrl_nxt = wdata_r[CTRL_W-1:0];
        MASK_OFS:   if (wstrb0_r) mask_nxt = wdata_r[NFLT-1:0];
        STATUS_OFS: ;
        LIVE_OFS:   ;
        default:    bresp_nxt = RESP_SLVERR;
      endcase
    end
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    // reads answer one cycle after the address is taken
    if (s_axi_arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      rdata_nxt  = 32'h0000_0000;
      unique case (s_axi_araddr)
        CTRL_OFS:   rdata_nxt[CTRL_W-1:0] = ctrl_r;
        STATUS_OFS: rdata_nxt[NFLT-1:0]   = status_r;
        MASK_OFS:   rdata_nxt[NFLT-1:0]   = mask_r;
        LIVE_OFS:   rdata_nxt[NFLT-1:0]   = live;
        default:    rresp_nxt             = RESP_SLVERR;
      endcase
    end
    awready_nxt = !aw_full_nxt;
    wready_nxt  = !w_full_nxt;
    arready_nxt = !rvalid_nxt;
    // pin pulls low for any live fault, warning included
    fault_n_nxt = !(|live);
    irq_nxt     = |(status_nxt & mask_nxt);
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_done_r <= 1'b0;
      hw_r         <= 1'b0;
      strap6_r     <= 1'b0;
      ctrl_r       <= CTRL_RST;
      status_r     <= FLT_RST;
      mask_r       <= MASK_RST;
      aw_full_r    <= 1'b0;
      awaddr_r     <= '0;
      w_full_r     <= 1'b0;
      wdata_r      <= 32'h0000_0000;
      wstrb0_r     <= 1'b0;
      awready_r    <= 1'b0;
      wready_r     <= 1'b0;
      bvalid_r     <= 1'b0;
      bresp_r      <= RESP_OKAY;
      arready_r    <= 1'b0;
      rvalid_r     <= 1'b0;
      rresp_r      <= RESP_OKAY;
      rdata_r      <= 32'h0000_0000;
      fault_n_r    <= 1'b1;
      irq_r        <= 1'b0;
    end else begin
      strap_done_r <= strap_done_nxt;
      hw_r         <= hw_nxt;
      strap6_r     <= strap6_nxt;
      ctrl_r       <= ctrl_nxt;
      status_r     <= status_nxt;
      mask_r       <= mask_nxt;
      aw_full_r    <= aw_full_nxt;
      awaddr_r     <= awaddr_nxt;
      w_full_r     <= w_full_nxt;
      wdata_r      <= wdata_nxt;
      wstrb0_r     <= wstrb0_nxt;
      awready_r    <= awready_nxt;
      wready_r     <= wready_nxt;
      bvalid_r     <= bvalid_nxt;
      bresp_r      <= bresp_nxt;
      arready_r    <= arready_nxt;
      rvalid_r     <= rvalid_nxt;
      rresp_r      <= rresp_nxt;
      rdata_r      <= rdata_nxt;
      fault_n_r    <= fault_n_nxt;
      irq_r        <= irq_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;
  assign fault_out_n   = fault_n_r;
  assign irq           = irq_r;

endmodule : gd_top

`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the gate drive control block
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import gd_pkg::*;
  localparam int RL = 200;
  localparam int RS = 50;
  logic        aclk, aresetn, hw_variant_strap, mode_strap_agnd, quiet, fault_out_n, irq;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        supply_lockout, gate_supply_undervoltage, thermal_shutdown, thermal_warning;
  logic [2:0]  high_side_input, low_side_input, overcurrent_in, gate_short_detect;
  logic [2:0]  high_gate_out, low_gate_out, phase_node_float, want_high, want_low;
  logic [8:0]  e;
  int          fail_count = 0, num_checks = 0, cyc = 0, n, f;
  int          filt[4] = '{FILT_CYC0, FILT_CYC1, FILT_CYC2, FILT_CYC3};
  int          flt[5] = '{FLT_LOCKOUT, FLT_GATE_SUPPLY_UNDERVOLTAGE, FLT_GSHORT, FLT_TSD, FLT_TWARN};

  gd_top #(.RETRY_LONG(RL), .RETRY_SHRT(RS)) u_gd_top (.*);
  gd_pwm_src u_gd_pwm_src (.*);

  // ********
  // clock, timeout and tasks
  // ********
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // ceiling well above the run length
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic wt(input int k);
    repeat (k) @(posedge aclk);
  endtask : wt
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd
  task automatic set_flt(input int b, input logic v);
    case (b)
      FLT_LOCKOUT: supply_lockout <= v;
      FLT_GATE_SUPPLY_UNDERVOLTAGE: gate_supply_undervoltage <= v;
      FLT_GSHORT: gate_short_detect <= {2'b00, v};
      FLT_TSD: thermal_shutdown <= v;
      default: thermal_warning <= v;
    endcase
  endtask : set_flt
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // ********
  // test sequence
  // ********
  initial begin
    {aresetn, hw_variant_strap, mode_strap_agnd, quiet} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {supply_lockout, gate_supply_undervoltage, thermal_shutdown, thermal_warning} = '0;
    {overcurrent_in, gate_short_detect, want_high, want_low} = '0;
    wt(20);
    aresetn <= 1'b1;
    wt(4);
    rd(CTRL_OFS);
    check({r, d}, 0);
    rd(8'h10);
    check({r, d}, {RESP_SLVERR, 32'h0000_0000});
    wr(8'h14, 32'hffff_ffff);
    check(r, RESP_SLVERR);
    // every request pair on all phases
    for (n = 0; n < 4; n++) begin
      want_high <= {3{n[0]}};
      want_low  <= {3{n[1]}};
      wt(8);
      e = (n == 1) ? 9'h1c0 : ((n == 2) ? 9'h038 : 9'h007);
      check({high_gate_out, low_gate_out, phase_node_float}, e);
    end
    // high to low: count dead window edges
    want_low <= 3'h0;
    wt(8);
    want_high <= 3'h0;
    want_low  <= 3'h7;
    for (n = 0; high_gate_out[0] !== 1'b0 && n < 10; n++) wt(1);
    for (n = 0; low_gate_out[0] !== 1'b1 && n < 10; n++) wt(1);
    check(n, DEAD_CYC + 1);
    // inputs parked low around each mode change
    quiet <= 1'b1;
    wr(CTRL_OFS, 32'h0000_0001);
    quiet <= 1'b0;
    want_high <= 3'h7;
    want_low  <= 3'h0;
    wt(8);
    check(high_gate_out, 3'h0);
    for (f = 0; f < 4; f++) begin
      quiet <= 1'b1;
      wr(CTRL_OFS, (f % 2) * 16 + f * 4);
      quiet <= 1'b0;
      wt(8);
      check(high_gate_out, 3'h7);
      // one cycle short: ignored
      overcurrent_in <= 3'h1;
      wt(filt[f] - 1);
      overcurrent_in <= 3'h0;
      rd(STATUS_OFS);
      check({d[FLT_OC], high_gate_out}, 4'h7);
      overcurrent_in <= 3'h1;
      wt(filt[f]);
      overcurrent_in <= 3'h0;
      wt((f % 2) ? RS - 20 : RL - 20);
      check(high_gate_out, 3'h0);
      wt(60);
      check(high_gate_out, 3'h7);
      rd(STATUS_OFS);
      check(d, 32'h0000_0004);
      wr(STATUS_OFS, 32'h0000_0004);
    end
    // each fault but overcurrent: pin, sticky bit, mask and clear
    for (n = 0; n < 5; n++) begin
      wr(MASK_OFS, (n % 2) << flt[n]);
      set_flt(flt[n], 1'b1);
      wt(6);
      check({fault_out_n, irq}, n % 2);
      set_flt(flt[n], 1'b0);
      rd(STATUS_OFS);
      check(d, 1 << flt[n]);
      wr(STATUS_OFS, 1 << flt[n]);
      wt(3);
      check({fault_out_n, irq}, 2'h2);
    end
    // reset into hardware variant
    {quiet, aresetn, hw_variant_strap, mode_strap_agnd} <= 4'hb;
    wt(2);
    aresetn <= 1'b1;
    wr(CTRL_OFS, 32'h0000_0011);
    quiet <= 1'b0;
    for (n = 0; n < 3; n++) begin
      wt(n == 2 ? 60 : 4);
      check(high_gate_out, {3{n < 2}});
      overcurrent_in <= {2'b00, n < 2};
      wt(FILT_CYC2 - 1 + n);
      overcurrent_in <= 3'h0;
    end
    end_of_test();
  end
endmodule : tb

`default_nettype wire
